/* File: cpi_unit.sv */
// Purpose: coprocessor instruction unit of the core pipeline
// Assumes: one instruction offered at a time, taken while o_ready is high
// Notes:   units 1..3 sit on an external port, unit 0 is internal
`timescale 1ns/1ns
`default_nettype none
module cpi_unit
  import cpi_pkg::*;
#(
  parameter logic [3:0] COP_PRESENT = 4'h1,
  parameter int         SC_NREGS    = 16
)(
  input  wire logic                 i_clk,
  input  wire logic                 i_rst,
  input  wire logic                 i_valid,
  input  wire logic [XLEN-1:0]      i_instr,
  input  wire logic [XLEN-1:0]      i_rt_value,
  input  wire logic [XLEN-1:0]      i_base_value,
  input  wire logic [XLEN-1:0]      i_delay_pc,
  output logic                      o_ready,
  output logic                      o_mem_re,
  output logic                      o_mem_we,
  output logic      [XLEN-1:0]      o_mem_addr,
  output logic      [XLEN-1:0]      o_mem_wdata,
  input  wire logic [XLEN-1:0]      i_mem_rdata,
  output logic                      o_cop_re,
  output logic                      o_cop_we,
  output logic                      o_cop_ctrl,
  output logic      [1:0]           o_cop_unit,
  output logic      [IDX_W-1:0]     o_cop_idx,
  output logic      [XLEN-1:0]      o_cop_wdata,
  input  wire logic [XLEN-1:0]      i_cop_rdata,
  output logic                      o_cop_op,
  output logic      [FUN_W-1:0]     o_cop_fun,
  input  wire logic [3:0]           i_cop_cond,
  output logic                      o_gpr_we,
  output logic      [IDX_W-1:0]     o_gpr_idx,
  output logic      [XLEN-1:0]      o_gpr_wdata,
  output logic                      o_br_valid,
  output logic                      o_br_taken,
  output logic      [XLEN-1:0]      o_br_target,
  output logic                      o_exc_valid,
  output logic      [4:0]           o_exc_cause,
  input  wire logic [IDX_W-1:0]     i_reg_addr,
  input  wire logic [XLEN-1:0]      i_reg_wdata,
  input  wire logic                 i_reg_we,
  input  wire logic                 i_reg_re,
  output logic      [XLEN-1:0]      o_reg_rdata
);
  import cpi_pkg::*;

  generate
    if (!COP_PRESENT[0])
    begin : g_bad
      $error("the system-control coprocessor must be present");
    end
  endgenerate

  typedef struct packed {
    cpi_state_t       state;
    cpi_kind_t        kind;
    logic [1:0]       unit;
    logic             ready;
    logic             mem_re;
    logic             mem_we;
    logic [XLEN-1:0]  mem_addr;
    logic [XLEN-1:0]  mem_wdata;
    logic             cop_re;
    logic             cop_we;
    logic             cop_ctrl;
    logic [1:0]       cop_unit;
    logic [IDX_W-1:0] cop_idx;
    logic [XLEN-1:0]  cop_wdata;
    logic             cop_op;
    logic [FUN_W-1:0] cop_fun;
    logic             gpr_we;
    logic [IDX_W-1:0] gpr_idx;
    logic [XLEN-1:0]  gpr_wdata;
    logic             br_valid;
    logic             br_taken;
    logic [XLEN-1:0]  br_target;
    logic             exc_valid;
    logic [4:0]       exc_cause;
    logic [XLEN-1:0]  reg_rdata;
  } cpi_core_state_t;

  cpi_core_state_t r_reg;
  cpi_core_state_t r_next;

  ////////////////////////////////////////////////////////////////////////////
  // decode

  logic             fire;
  logic [3:0]       grp;
  logic [1:0]       unit;
  logic             present;
  logic             internal;
  logic [4:0]       rs;
  logic [IDX_W-1:0] rt;
  logic [IDX_W-1:0] rd;
  logic [5:0]       fn;
  logic [XLEN-1:0]  sext_imm;
  logic [XLEN-1:0]  eff_addr;
  logic [XLEN-1:0]  br_tgt;
  logic             is_lwc;
  logic             is_swc;
  logic             is_cop;
  logic             is_co;
  logic             is_xlat;

  assign fire     = i_valid && r_reg.ready;
  assign grp      = i_instr[GRP_HI:GRP_LO];
  assign unit     = i_instr[UNIT_HI:UNIT_LO];
  assign present  = COP_PRESENT[unit];
  assign internal = (unit == 2'h0);
  assign rs       = i_instr[RS_HI:RS_LO];
  assign rt       = i_instr[RT_HI:RT_LO];
  assign rd       = i_instr[RD_HI:RD_LO];
  assign fn       = i_instr[FN_HI:FN_LO];
  // immediate format for loads and stores
  assign sext_imm = XLEN'($signed(i_instr[IMM_HI:0]));
  assign eff_addr = i_base_value + sext_imm;
  assign br_tgt   = i_delay_pc + (sext_imm << BR_SHIFT);
  assign is_lwc   = (grp == GRP_LWC);
  assign is_swc   = (grp == GRP_SWC);
  assign is_cop   = (grp == GRP_COP);
  assign is_co    = i_instr[CO_BIT];
  assign is_xlat  = (fn == FN_XLAT_RD) || (fn == FN_XLAT_WI) ||
                    (fn == FN_XLAT_WR) || (fn == FN_XLAT_PRB);

  ////////////////////////////////////////////////////////////////////////////
  // system-control coprocessor registers

  logic             iw_inst;
  logic [IDX_W-1:0] iw_idx;
  logic [XLEN-1:0]  iw_data;
  logic             sc_rfe;
  logic             sc_we;
  logic [IDX_W-1:0] sc_widx;
  logic [XLEN-1:0]  sc_wdata;
  logic [XLEN-1:0]  sc_rdata_a;
  logic [XLEN-1:0]  sc_rdata_b;
  logic [XLEN-1:0]  sc_status;

  // a bus write colliding with an instruction update is dropped
  assign sc_we    = iw_inst || (i_reg_we && !sc_rfe);
  assign sc_widx  = iw_inst ? iw_idx : i_reg_addr;
  assign sc_wdata = iw_inst ? iw_data : i_reg_wdata;

  cpi_sysctl_regs #(
    .NREGS     (SC_NREGS)
  ) u_sc (
    .i_clk     (i_clk),
    .i_rst     (i_rst),
    .i_we      (sc_we),
    .i_widx    (sc_widx),
    .i_wdata   (sc_wdata),
    .i_rfe     (sc_rfe),
    .i_ridx_a  (is_swc ? rt : rd),
    .i_ridx_b  (i_reg_addr),
    .o_rdata_a (sc_rdata_a),
    .o_rdata_b (sc_rdata_b),
    .o_status  (sc_status)
  );

  ////////////////////////////////////////////////////////////////////////////
  // sequencing

  always_comb
  begin
    r_next           = r_reg;
    r_next.mem_re    = 1'b0;
    r_next.mem_we    = 1'b0;
    r_next.cop_re    = 1'b0;
    r_next.cop_we    = 1'b0;
    r_next.cop_op    = 1'b0;
    r_next.gpr_we    = 1'b0;
    r_next.br_valid  = 1'b0;
    r_next.exc_valid = 1'b0;
    r_next.reg_rdata = i_reg_re ? sc_rdata_b : '0;
    iw_inst          = 1'b0;
    iw_idx           = rd;
    iw_data          = i_rt_value;
    sc_rfe           = 1'b0;
    case (r_reg.state)
      CPI_IDLE:
      begin
        if (fire && (is_lwc || is_swc || is_cop) && !present)
        begin
          r_next.exc_valid = 1'b1;
          r_next.exc_cause = EXC_COP_ABSENT;
        end
        else if (fire && is_lwc)
        begin
          r_next.mem_re   = 1'b1;
          r_next.mem_addr = eff_addr;
          r_next.kind     = CPI_K_LOAD;
          r_next.unit     = unit;
          r_next.cop_idx  = rt;
          r_next.ready    = 1'b0;
          r_next.state    = CPI_WAIT;
        end
        else if (fire && is_swc && internal)
        begin
          r_next.mem_we    = 1'b1;
          r_next.mem_addr  = eff_addr;
          r_next.mem_wdata = sc_rdata_a;
        end
        else if (fire && is_swc)
        begin
          r_next.cop_re   = 1'b1;
          r_next.cop_ctrl = 1'b0;
          r_next.cop_unit = unit;
          r_next.cop_idx  = rt;
          r_next.mem_addr = eff_addr;
          r_next.kind     = CPI_K_STORE;
          r_next.ready    = 1'b0;
          r_next.state    = CPI_WAIT;
        end
        else if (fire && is_cop && is_co && internal)
        begin
          if (fn == FN_RFE)
          begin
            sc_rfe = 1'b1;
          end
          else
          begin
            // translation-buffer and unknown functions trap
            r_next.exc_valid = 1'b1;
            r_next.exc_cause = EXC_RESERVED;
          end
        end
        else if (fire && is_cop && is_co)
        begin
          // unit-defined format; nothing in the core is written
          r_next.cop_op   = 1'b1;
          r_next.cop_unit = unit;
          r_next.cop_fun  = i_instr[FUN_W-1:0];
        end
        else if (fire && is_cop && rs == RS_BC)
        begin
          r_next.br_valid  = 1'b1;
          r_next.br_target = br_tgt;
          // true form follows the line, false form its inverse
          r_next.br_taken  = (i_cop_cond[unit] == i_instr[TF_BIT]);
        end
        else if (fire && is_cop && internal && rs == RS_MT)
        begin
          iw_inst = 1'b1;
        end
        else if (fire && is_cop && internal && rs == RS_MF)
        begin
          r_next.gpr_we    = 1'b1;
          r_next.gpr_idx   = rt;
          r_next.gpr_wdata = sc_rdata_a;
        end
        else if (fire && is_cop && !internal && (rs == RS_MT || rs == RS_CT))
        begin
          r_next.cop_we    = 1'b1;
          r_next.cop_ctrl  = (rs == RS_CT);
          r_next.cop_unit  = unit;
          r_next.cop_idx   = rd;
          r_next.cop_wdata = i_rt_value;
        end
        else if (fire && is_cop && !internal && (rs == RS_MF || rs == RS_CF))
        begin
          r_next.cop_re   = 1'b1;
          r_next.cop_ctrl = (rs == RS_CF);
          r_next.cop_unit = unit;
          r_next.cop_idx  = rd;
          r_next.gpr_idx  = rt;
          r_next.kind     = CPI_K_MOVE;
          r_next.ready    = 1'b0;
          r_next.state    = CPI_WAIT;
        end
        else if (fire && is_cop)
        begin
          // control moves on unit 0 and unknown sub-operations
          r_next.exc_valid = 1'b1;
          r_next.exc_cause = EXC_RESERVED;
        end
      end
      CPI_WAIT:
      begin
        r_next.state = CPI_CAPTURE;
      end
      CPI_CAPTURE:
      begin
        r_next.state = CPI_IDLE;
        r_next.ready = 1'b1;
        case (r_reg.kind)
          CPI_K_LOAD:
          begin
            if (r_reg.unit == 2'h0)
            begin
              iw_inst = 1'b1;
              iw_idx  = r_reg.cop_idx;
              iw_data = i_mem_rdata;
            end
            else
            begin
              r_next.cop_we    = 1'b1;
              r_next.cop_ctrl  = 1'b0;
              r_next.cop_unit  = r_reg.unit;
              r_next.cop_wdata = i_mem_rdata;
            end
          end
          CPI_K_STORE:
          begin
            r_next.mem_we    = 1'b1;
            r_next.mem_wdata = i_cop_rdata;
          end
          default:
          begin
            r_next.gpr_we    = 1'b1;
            r_next.gpr_wdata = i_cop_rdata;
          end
        endcase
      end
      default:
      begin
        r_next.state = CPI_IDLE;
        r_next.ready = 1'b1;
      end
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      r_reg       <= '0;
      r_reg.state <= CPI_IDLE;
      r_reg.ready <= 1'b1;
    end
    else
    begin
      r_reg <= r_next;
    end
  end

  assign o_ready     = r_reg.ready;
  assign o_mem_re    = r_reg.mem_re;
  assign o_mem_we    = r_reg.mem_we;
  assign o_mem_addr  = r_reg.mem_addr;
  assign o_mem_wdata = r_reg.mem_wdata;
  assign o_cop_re    = r_reg.cop_re;
  assign o_cop_we    = r_reg.cop_we;
  assign o_cop_ctrl  = r_reg.cop_ctrl;
  assign o_cop_unit  = r_reg.cop_unit;
  assign o_cop_idx   = r_reg.cop_idx;
  assign o_cop_wdata = r_reg.cop_wdata;
  assign o_cop_op    = r_reg.cop_op;
  assign o_cop_fun   = r_reg.cop_fun;
  assign o_gpr_we    = r_reg.gpr_we;
  assign o_gpr_idx   = r_reg.gpr_idx;
  assign o_gpr_wdata = r_reg.gpr_wdata;
  assign o_br_valid  = r_reg.br_valid;
  assign o_br_taken  = r_reg.br_taken;
  assign o_br_target = r_reg.br_target;
  assign o_exc_valid = r_reg.exc_valid;
  assign o_exc_cause = r_reg.exc_cause;
  assign o_reg_rdata = r_reg.reg_rdata;

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  logic ext_ok;
  assign ext_ok = fire && present && !internal;

  property p_ld_addr;
    fire && is_lwc && present |=> o_mem_re && o_mem_addr == $past(eff_addr);
  endproperty
  a_ld_addr: assert property (p_ld_addr) else $error("load address wrong");

  sequence s_ld_issue;
    o_mem_re && r_reg.unit != 2'h0;
  endsequence
  property p_ld_data;
    s_ld_issue |=> ##1 (o_cop_we && !o_cop_ctrl && o_cop_wdata == $past(i_mem_rdata));
  endproperty
  a_ld_data: assert property (p_ld_data) else $error("load data not delivered");

  sequence s_st_issue;
    ext_ok && is_swc ##1 o_cop_re;
  endsequence
  property p_st;
    s_st_issue |=> ##1 (o_mem_we && o_mem_wdata == $past(i_cop_rdata) &&
                        o_mem_addr == $past(eff_addr, 3));
  endproperty
  a_st: assert property (p_st) else $error("store data or address wrong");

  property p_mt;
    ext_ok && is_cop && !is_co && (rs == RS_MT || rs == RS_CT) |=>
      o_cop_we && o_cop_ctrl == $past(rs == RS_CT) &&
      o_cop_wdata == $past(i_rt_value) && o_cop_idx == $past(rd);
  endproperty
  a_mt: assert property (p_mt) else $error("move to coprocessor wrong");

  property p_mf;
    o_cop_re && r_reg.kind == CPI_K_MOVE |=> !o_gpr_we ##1
      (o_gpr_we && o_gpr_wdata == $past(i_cop_rdata));
  endproperty
  a_mf: assert property (p_mf) else $error("move from coprocessor wrong");

  // a bus write in the same cycle may legally move the status word, so it is excluded
  property p_cop_op;
    fire && is_cop && is_co && !internal && present && !i_reg_we |=>
      o_cop_op && o_cop_unit == $past(unit) && o_cop_fun == $past(i_instr[FUN_W-1:0]) &&
      !o_gpr_we && !o_mem_we && !o_mem_re && !o_exc_valid && $stable(sc_status);
  endproperty
  a_cop_op: assert property (p_cop_op) else $error("operation touched core");

  property p_branch;
    fire && is_cop && !is_co && rs == RS_BC && present |=> o_br_valid &&
      o_br_target == $past(i_delay_pc) + ($past(sext_imm) << BR_SHIFT) &&
      o_br_taken == ($past(i_cop_cond[unit]) ~^ $past(i_instr[TF_BIT]));
  endproperty
  a_branch: assert property (p_branch) else $error("branch wrong");

  property p_sc_mt;
    fire && is_cop && internal && !is_co && rs == RS_MT && rd == STATUS_IDX
      |=> sc_status == $past(i_rt_value);
  endproperty
  a_sc_mt: assert property (p_sc_mt) else $error("control write lost");

  property p_sc_mf;
    fire && is_cop && internal && !is_co && rs == RS_MF |=>
      o_gpr_we && o_gpr_idx == $past(rt) && o_gpr_wdata == $past(sc_rdata_a);
  endproperty
  a_sc_mf: assert property (p_sc_mf) else $error("control read wrong");

  property p_rfe;
    fire && is_cop && internal && is_co && fn == FN_RFE |=>
      sc_status[ST_PREV_LO-1:0] == $past(sc_status[ST_OLD_LO-1:ST_PREV_LO]) &&
      sc_status[ST_OLD_LO-1:ST_PREV_LO] == $past(sc_status[ST_OLD_LO+1:ST_OLD_LO]);
  endproperty
  a_rfe: assert property (p_rfe) else $error("status stack not popped");

  property p_xlat;
    fire && is_cop && internal && is_co && is_xlat |=>
      o_exc_valid && o_exc_cause == EXC_RESERVED && !o_gpr_we;
  endproperty
  a_xlat: assert property (p_xlat) else $error("reserved op not trapped");

  property p_absent;
    fire && (is_lwc || is_swc || is_cop) && !present |=>
      o_exc_valid && o_exc_cause == EXC_COP_ABSENT && !o_mem_re && !o_cop_we;
  endproperty
  a_absent: assert property (p_absent) else $error("absent unit not trapped");
endmodule
`default_nettype wire

/* File: cpi_pkg.sv */
// Purpose: shared constants and types of the coprocessor instruction unit
// Assumes: 32-bit instruction words, four coprocessor unit numbers
// Notes:   unit 0 is the on-chip system-control coprocessor
package cpi_pkg;
  localparam int XLEN     = 32;
  localparam int IDX_W    = 5;
  localparam int IMM_W    = 16;
  localparam int FUN_W    = 25;
  localparam int BR_SHIFT = 2;
  // instruction field positions
  localparam int GRP_HI  = 31;
  localparam int GRP_LO  = 28;
  localparam int UNIT_HI = 27;
  localparam int UNIT_LO = 26;
  localparam int RS_HI   = 25;
  localparam int RS_LO   = 21;
  localparam int CO_BIT  = 25;
  localparam int RT_HI   = 20;
  localparam int RT_LO   = 16;
  localparam int TF_BIT  = 16;
  localparam int RD_HI   = 15;
  localparam int RD_LO   = 11;
  localparam int IMM_HI  = 15;
  localparam int FN_HI   = 5;
  localparam int FN_LO   = 0;
  // opcode groups (upper four opcode bits)
  localparam logic [3:0] GRP_COP = 4'h4;
  localparam logic [3:0] GRP_LWC = 4'hC;
  localparam logic [3:0] GRP_SWC = 4'hE;
  // sub-operation in the rs field
  localparam logic [4:0] RS_MF = 5'h00;
  localparam logic [4:0] RS_CF = 5'h02;
  localparam logic [4:0] RS_MT = 5'h04;
  localparam logic [4:0] RS_CT = 5'h06;
  localparam logic [4:0] RS_BC = 5'h08;
  // system-control coprocessor function codes
  localparam logic [5:0] FN_XLAT_RD  = 6'h01;
  localparam logic [5:0] FN_XLAT_WI  = 6'h02;
  localparam logic [5:0] FN_XLAT_WR  = 6'h06;
  localparam logic [5:0] FN_XLAT_PRB = 6'h08;
  localparam logic [5:0] FN_RFE      = 6'h10;
  // status register and its mode stack
  localparam logic [IDX_W-1:0] STATUS_IDX = 5'h0C;
  localparam logic [XLEN-1:0]  STATUS_RST = 32'h0000_0000;
  localparam int ST_CUR_LO  = 0;
  localparam int ST_PREV_LO = 2;
  localparam int ST_OLD_LO  = 4;
  localparam int ST_PAIR_W  = 2;
  // exception causes
  localparam logic [4:0] EXC_RESERVED  = 5'h0A;
  localparam logic [4:0] EXC_COP_ABSENT = 5'h0B;

  typedef enum logic [1:0] {
    CPI_IDLE    = 2'b00,
    CPI_WAIT    = 2'b01,
    CPI_CAPTURE = 2'b10
  } cpi_state_t;

  typedef enum logic [1:0] {
    CPI_K_LOAD  = 2'b00,
    CPI_K_STORE = 2'b01,
    CPI_K_MOVE  = 2'b10
  } cpi_kind_t;
endpackage

/* File: cpi_sysctl_regs.sv */
// Purpose: register file of the system-control coprocessor
// Assumes: one write port, two combinational read ports
// Notes:   return-from-exception pops the status mode stack
`timescale 1ns/1ns
`default_nettype none
module cpi_sysctl_regs
  import cpi_pkg::*;
#(
  parameter int NREGS = 16
)(
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  input  wire logic             i_we,
  input  wire logic [IDX_W-1:0] i_widx,
  input  wire logic [XLEN-1:0]  i_wdata,
  input  wire logic             i_rfe,
  input  wire logic [IDX_W-1:0] i_ridx_a,
  input  wire logic [IDX_W-1:0] i_ridx_b,
  output logic      [XLEN-1:0]  o_rdata_a,
  output logic      [XLEN-1:0]  o_rdata_b,
  output logic      [XLEN-1:0]  o_status
);
  import cpi_pkg::*;

  generate
    if (NREGS <= STATUS_IDX || NREGS > (1 << IDX_W))
    begin : g_bad
      $error("NREGS must hold the status register and fit the index");
    end
  endgenerate

  typedef struct packed {
    logic [NREGS-1:0][XLEN-1:0] regs;
  } cpi_sc_state_t;

  cpi_sc_state_t r_reg;
  cpi_sc_state_t r_next;
  logic [XLEN-1:0] st;

  always_comb
  begin
    r_next = r_reg;
    if (i_we && 32'(i_widx) < NREGS)
    begin
      r_next.regs[i_widx] = i_wdata;
    end
    st = r_next.regs[STATUS_IDX];
    if (i_rfe)
    begin
      // old pair moves to previous, previous to current; old stays
      st[ST_CUR_LO +: ST_PAIR_W]  = st[ST_PREV_LO +: ST_PAIR_W];
      st[ST_PREV_LO +: ST_PAIR_W] = st[ST_OLD_LO +: ST_PAIR_W];
    end
    r_next.regs[STATUS_IDX] = st;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      r_reg.regs             <= '0;
      r_reg.regs[STATUS_IDX] <= STATUS_RST;
    end
    else
    begin
      r_reg <= r_next;
    end
  end

  assign o_rdata_a = (32'(i_ridx_a) < NREGS) ? r_reg.regs[i_ridx_a] : '0;
  assign o_rdata_b = (32'(i_ridx_b) < NREGS) ? r_reg.regs[i_ridx_b] : '0;
  assign o_status  = r_reg.regs[STATUS_IDX];
endmodule
`default_nettype wire

/* File: cpi_cop_model.sv */
// Purpose: far-side coprocessor units and data memory for the unit bench
// Assumes: read data answered in the cycle after a read strobe
// Notes:   outside that cycle the data lines toggle so stale values never match
`timescale 1ns/1ns
`default_nettype none
module cpi_cop_model #(
  parameter logic [31:0] MEM_KEY = 32'hA5A5_0000
)(
  input  wire logic        i_clk,
  input  wire logic        i_mem_re,
  input  wire logic [31:0] i_mem_addr,
  output logic      [31:0] o_mem_rdata,
  input  wire logic        i_cop_re,
  input  wire logic        i_cop_we,
  input  wire logic        i_cop_ctrl,
  input  wire logic [1:0]  i_cop_unit,
  input  wire logic [4:0]  i_cop_idx,
  input  wire logic [31:0] i_cop_wdata,
  output logic      [31:0] o_cop_rdata
);
  // data and control spaces kept apart per unit
  logic [31:0] regs [2][4][32];
  initial o_mem_rdata = 32'h0;
  initial o_cop_rdata = 32'h0;
  always @(posedge i_clk)
  begin
    o_mem_rdata <= i_mem_re ? i_mem_addr ^ MEM_KEY : ~o_mem_rdata;
    o_cop_rdata <= i_cop_re ? regs[i_cop_ctrl][i_cop_unit][i_cop_idx] : ~o_cop_rdata;
    if (i_cop_we)
      regs[i_cop_ctrl][i_cop_unit][i_cop_idx] <= i_cop_wdata;
  end
endmodule
`default_nettype wire

/* File: tb_cpi_unit.sv */
// Purpose: self-checking bench of the coprocessor instruction unit
// Assumes: units 0..2 present, unit 3 absent
// Notes:   branch and translation-buffer cases run from tables, the rest by hand
`timescale 1ns/1ns
`default_nettype none
module tb_cpi_unit;
  import cpi_pkg::*;
  localparam logic [31:0] KEY = 32'hA5A5_0000;
  typedef struct {logic [31:0] ins; logic [3:0] cnd; logic tk; logic [31:0] tgt;} cpi_row_t;
  logic i_clk = 0, i_rst = 1, i_valid = 0, i_reg_we = 0, i_reg_re = 0;
  logic [31:0] i_instr = 0, i_rt_value = 0, i_base_value = 32'h100, i_delay_pc = 32'h1000;
  logic [31:0] i_reg_wdata = 0, i_mem_rdata, i_cop_rdata;
  logic [4:0]  i_reg_addr = 0;
  logic [3:0]  i_cop_cond = 0;
  logic o_ready, o_mem_re, o_mem_we, o_cop_re, o_cop_we, o_cop_ctrl, o_cop_op;
  logic o_gpr_we, o_br_valid, o_br_taken, o_exc_valid;
  logic [31:0] o_mem_addr, o_mem_wdata, o_cop_wdata, o_gpr_wdata, o_br_target, o_reg_rdata;
  logic [1:0]  o_cop_unit;
  logic [4:0]  o_cop_idx, o_gpr_idx, o_exc_cause;
  logic [24:0] o_cop_fun;
  int miscompares = 0, n_checks = 0, cyc = 0;
  cpi_row_t rows [5];
  localparam logic [5:0] XLAT_FN [4] = '{FN_XLAT_RD, FN_XLAT_WI, FN_XLAT_WR, FN_XLAT_PRB};
  wire logic [33:0] brw = {o_br_valid, o_br_taken, o_br_target};
  wire logic [40:0] copw = {o_cop_we, o_cop_ctrl, o_cop_unit, o_cop_idx, o_cop_wdata};
  wire logic [30:0] opw = {o_cop_op, o_cop_unit, o_cop_fun, o_gpr_we, o_mem_we, o_cop_we};
  cpi_unit #(.COP_PRESENT(4'h7), .SC_NREGS(16)) uut (.i_clk(i_clk), .i_rst(i_rst),
    .i_valid(i_valid), .i_instr(i_instr), .i_rt_value(i_rt_value),
    .i_base_value(i_base_value), .i_delay_pc(i_delay_pc), .o_ready(o_ready),
    .o_mem_re(o_mem_re), .o_mem_we(o_mem_we), .o_mem_addr(o_mem_addr),
    .o_mem_wdata(o_mem_wdata), .i_mem_rdata(i_mem_rdata), .o_cop_re(o_cop_re),
    .o_cop_we(o_cop_we), .o_cop_ctrl(o_cop_ctrl), .o_cop_unit(o_cop_unit),
    .o_cop_idx(o_cop_idx), .o_cop_wdata(o_cop_wdata), .i_cop_rdata(i_cop_rdata),
    .o_cop_op(o_cop_op), .o_cop_fun(o_cop_fun), .i_cop_cond(i_cop_cond),
    .o_gpr_we(o_gpr_we), .o_gpr_idx(o_gpr_idx), .o_gpr_wdata(o_gpr_wdata),
    .o_br_valid(o_br_valid), .o_br_taken(o_br_taken), .o_br_target(o_br_target),
    .o_exc_valid(o_exc_valid), .o_exc_cause(o_exc_cause), .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata), .i_reg_we(i_reg_we), .i_reg_re(i_reg_re),
    .o_reg_rdata(o_reg_rdata));
  cpi_cop_model #(.MEM_KEY(KEY)) far (.i_clk(i_clk), .i_mem_re(o_mem_re),
    .i_mem_addr(o_mem_addr), .o_mem_rdata(i_mem_rdata), .i_cop_re(o_cop_re),
    .i_cop_we(o_cop_we), .i_cop_ctrl(o_cop_ctrl), .i_cop_unit(o_cop_unit),
    .i_cop_idx(o_cop_idx), .i_cop_wdata(o_cop_wdata), .o_cop_rdata(i_cop_rdata));
  always #20 i_clk = ~i_clk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic finish_test;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    n_checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // returns just after the first edge where N=1 outputs stand
  task automatic issue(input logic [31:0] ins, input logic [31:0] rt);
    @(posedge i_clk);
    i_valid <= 1'b1;
    i_instr <= ins;
    i_rt_value <= rt;
    @(posedge i_clk);
    i_valid <= 1'b0;
    #1;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_reg_we <= 1'b1;
    i_reg_addr <= a;
    i_reg_wdata <= d;
    @(posedge i_clk);
    i_reg_we <= 1'b0;
  endtask
  task automatic rdc(input logic [4:0] a, input logic [31:0] e);
    @(posedge i_clk);
    i_reg_re <= 1'b1;
    i_reg_addr <= a;
    @(posedge i_clk);
    i_reg_re <= 1'b0;
    #1;
    chk(o_reg_rdata, e);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // bounded run: a hang ends as a failure
  always @(posedge i_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      miscompares++;
      finish_test();
    end
  end
  initial
  begin
    rows = '{'{32'h4101_0004, 4'h1, 1'b1, 32'h0000_1010},
             '{32'h4100_0004, 4'h1, 1'b0, 32'h0000_1010},
             '{32'h4501_FFFF, 4'h0, 1'b0, 32'h0000_0FFC},
             '{32'h4500_FFFF, 4'h0, 1'b1, 32'h0000_0FFC},
             '{32'h4901_8000, 4'h4, 1'b1, 32'hFFFE_1000}};
    repeat (3) @(posedge i_clk);
    i_rst <= 1'b0;
    #1;
    chk(o_ready, 1'b1);
    rdc(STATUS_IDX, 32'h0);
    foreach (rows[i])
    begin
      i_cop_cond <= rows[i].cnd;
      issue(rows[i].ins, 32'h0);
      chk(brw, {1'b1, rows[i].tk, rows[i].tgt});
    end
    wr(5'h03, 32'h1234_5678);
    rdc(5'h03, 32'h1234_5678);
    rdc(5'h10, 32'h0);
    issue(32'h4082_2000, 32'hCAFE_0001);
    rdc(5'h04, 32'hCAFE_0001);
    issue(32'h4007_2000, 32'h0);
    chk({o_gpr_we, o_gpr_idx, o_gpr_wdata}, {1'b1, 5'h07, 32'hCAFE_0001});
    // old=11 prev=10 cur=01 pops to old=11 prev=11 cur=10
    wr(STATUS_IDX, 32'h39);
    issue(32'h4200_0010, 32'h0);
    rdc(STATUS_IDX, 32'h3E);
    for (int k = 0; k < 4; k++)
    begin
      issue(32'h4200_0000 | {26'h0, XLAT_FN[k]}, 32'h0);
      chk({o_exc_valid, o_exc_cause, o_gpr_we}, {1'b1, EXC_RESERVED, 1'b0});
    end
    issue(32'h40C0_0000, 32'h0);
    chk({o_exc_valid, o_exc_cause}, {1'b1, EXC_RESERVED});
    issue(32'h4C80_0000, 32'h0);
    chk({o_exc_valid, o_exc_cause, o_cop_we}, {1'b1, EXC_COP_ABSENT, 1'b0});
    issue(32'h4480_4800, 32'h1111_2222);
    chk(copw, {4'h9, 5'h09, 32'h1111_2222});
    issue(32'h44C0_4800, 32'h3333_4444);
    chk({o_cop_we, o_cop_ctrl, o_cop_wdata}, {2'h3, 32'h3333_4444});
    issue(32'h4405_4800, 32'h0);
    wt(2);
    chk({o_gpr_we, o_gpr_idx, o_gpr_wdata}, {1'b1, 5'h05, 32'h1111_2222});
    issue(32'h4446_4800, 32'h0);
    wt(2);
    chk({o_gpr_we, o_gpr_idx, o_gpr_wdata}, {1'b1, 5'h06, 32'h3333_4444});
    issue(32'hC409_FFF8, 32'h0);
    chk({o_mem_re, o_mem_addr, o_ready}, {1'b1, 32'hF8, 1'b0});
    wt(2);
    chk(copw, {4'h9, 5'h09, 32'hF8 ^ KEY});
    issue(32'hE409_0010, 32'h0);
    chk({o_cop_re, o_cop_idx}, {1'b1, 5'h09});
    wt(2);
    chk({o_mem_we, o_mem_addr, o_mem_wdata}, {1'b1, 32'h110, 32'hF8 ^ KEY});
    issue(32'h4A12_3456, 32'h0);
    chk(opw, {3'h6, 25'h012_3456, 3'h0});
    // unit 0 load lands in the internal file one cycle after the bus answer
    issue(32'hC003_0004, 32'h0);
    wt(1);
    rdc(5'h03, 32'h104 ^ KEY);
    issue(32'hE003_0020, 32'h0);
    chk({o_mem_we, o_mem_addr, o_mem_wdata}, {1'b1, 32'h120, 32'h104 ^ KEY});
    // mid-run reset: outputs, ready and the status stack go back to reset values
    @(posedge i_clk);
    i_rst <= 1'b1;
    @(posedge i_clk);
    i_rst <= 1'b0;
    #1;
    chk({o_ready, o_mem_addr, o_cop_op, o_exc_valid}, {1'b1, 34'h0});
    rdc(STATUS_IDX, 32'h0);
    finish_test();
  end
endmodule
`default_nettype wire
